// [shared/bmc_defines.svh]
// Constants for the bus-management compare-swap and ROM header register bank.
`ifndef BMC_DEFINES_SVH
`define BMC_DEFINES_SVH

`define BMC_AW 8
`define BMC_DW 32
`define BMC_NRES 4
`define BMC_SELW 2

`define BMC_OFF_DATA 8'h0c
`define BMC_OFF_CMP 8'h10
`define BMC_OFF_CTRL 8'h14
`define BMC_OFF_ROMH 8'h18
`define BMC_OFF_BUSID 8'h1c
`define BMC_OFF_CMP_LOAD 8'h30
`define BMC_OFF_DATA_LOAD 8'h34
`define BMC_OFF_OLD 8'h38
`define BMC_OFF_INT_STAT 8'h40
`define BMC_OFF_INT_MASK 8'h44

`define BMC_DONE_BIT 31
`define BMC_SEL_MSB 1
`define BMC_SEL_LSB 0
`define BMC_INFO_MSB 31
`define BMC_INFO_LSB 24
`define BMC_CRCL_MSB 23
`define BMC_CRCL_LSB 16
`define BMC_CRC_MSB 15
`define BMC_CRC_LSB 0

`define BMC_BUSID_VALUE 32'h31333934
`define BMC_DONE_RST 1'b1
`define BMC_SEL_RST 2'h0
`define BMC_BYTE_RST 8'h00
`define BMC_CRC_RST 16'h0000
`define BMC_WORD_RST 32'h00000000

`define BMC_INTW 2
`define BMC_INT_DONE 0
`define BMC_INT_MATCH 1
`define BMC_INT_RST 2'h0

`endif

// [shared/bmc_pkg.sv]
// Types and address decode shared by the register bank files.
`include "bmc_defines.svh"
package bmc_pkg;
  typedef enum logic [1:0] {BMC_IDLE = 2'h0, BMC_BUSY = 2'h1} bmc_state_e;
  typedef logic [`BMC_SELW-1:0] bmc_sel_t;
  typedef logic [`BMC_AW-1:0] bmc_addr_t;
  typedef logic [`BMC_DW-1:0] bmc_word_t;

  // Tells whether an address holds a register of this bank.
  function automatic logic bmc_mapped(input bmc_addr_t a);
    logic m;
    m = 1'b0;
    case (a)
      `BMC_OFF_DATA, `BMC_OFF_CMP, `BMC_OFF_CTRL, `BMC_OFF_ROMH, `BMC_OFF_BUSID,
      `BMC_OFF_CMP_LOAD, `BMC_OFF_DATA_LOAD, `BMC_OFF_OLD, `BMC_OFF_INT_STAT,
      `BMC_OFF_INT_MASK: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

  // Merges write data into a word under byte strobes.
  function automatic bmc_word_t bmc_merge(input bmc_word_t old, input bmc_word_t wd, input logic [3:0] st);
    bmc_word_t r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// [hdl/bmc_apb_slave.sv]
// APB access decode with wait states while a swap is running.
`timescale 1ns/1ps
`default_nettype none
module bmc_apb_slave (
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire bmc_pkg::bmc_addr_t paddr,
  input wire logic busy,
  output logic pready,
  output logic pslverr,
  output logic wr_en,
  output logic rd_en
);
  import bmc_pkg::*;

  logic access;

  assign access = psel && penable;
  assign pready = !busy;
  assign pslverr = access && pready && !bmc_mapped(paddr);
  assign wr_en = access && pready && pwrite && bmc_mapped(paddr);
  assign rd_en = access && pready && !pwrite;
endmodule
`default_nettype wire

// [hdl/bmc_swap_unit.sv]
// Bus-management resources with an atomic compare-swap port.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defines.svh"
module bmc_swap_unit #(
  parameter logic [`BMC_NRES*`BMC_DW-1:0] RES_RESET = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire bmc_pkg::bmc_sel_t sel,
  input wire bmc_pkg::bmc_word_t cmp,
  input wire bmc_pkg::bmc_word_t data,
  output logic done_q,
  output logic match_q,
  output bmc_pkg::bmc_word_t old_q,
  output logic [`BMC_NRES*`BMC_DW-1:0] res_flat
);
  import bmc_pkg::*;

  bmc_word_t res_q [`BMC_NRES];
  logic hit;

  assign hit = (res_q[sel] == cmp);

  genvar g;
  generate
    for (g = 0; g < `BMC_NRES; g++)
    begin : g_res
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          res_q[g] <= RES_RESET[g*`BMC_DW +: `BMC_DW];
        else if (start && hit && (sel == g))
          res_q[g] <= data;
      end
      assign res_flat[g*`BMC_DW +: `BMC_DW] = res_q[g];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q <= 1'b0;
      match_q <= 1'b0;
      old_q <= `BMC_WORD_RST;
    end
    else
    begin
      done_q <= start;
      if (start)
      begin
        match_q <= hit;
        old_q <= res_q[sel];
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/bmc_regs.sv]
// Register bank for compare-swap control, ROM header and bus identification.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defines.svh"
module bmc_regs #(
  parameter logic [`BMC_NRES*`BMC_DW-1:0] RES_RESET = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire bmc_pkg::bmc_addr_t paddr,
  input wire bmc_pkg::bmc_word_t pwdata,
  input wire logic [3:0] pstrb,
  output bmc_pkg::bmc_word_t prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic eeprom_present,
  input wire logic [15:0] eeprom_crc,
  input wire logic link_on_bit,
  output bmc_pkg::bmc_word_t rom_header,
  output logic rom_header_live,
  output logic [`BMC_NRES*`BMC_DW-1:0] res_values
);
  import bmc_pkg::*;

  localparam int SWAP_MIN = 1;
  localparam int SWAP_MAX = 2;

  bmc_state_e state_q;
  bmc_state_e state_d;
  logic wr_en;
  logic start_q;
  logic swap_done;
  logic swap_match;
  bmc_word_t old_value;
  bmc_word_t cmp_q;
  bmc_word_t data_q;
  logic swap_complete_flag_q;
  bmc_sel_t resource_select_q;
  logic [7:0] info_len_q;
  logic [7:0] crc_len_q;
  logic [15:0] rom_crc_q;
  logic boot_q;
  logic [`BMC_INTW-1:0] int_stat_q;
  logic [`BMC_INTW-1:0] int_mask_q;
  logic [`BMC_INTW-1:0] int_event;
  bmc_word_t rd_value;
  bmc_word_t prdata_q;
  logic wr_ctrl;
  logic wr_romh;
  logic wr_stat;
  logic wr_mask;
  logic wr_cmp_load;
  logic wr_data_load;
  logic settle_q;
  bmc_word_t romh_merged;
  bmc_word_t sel_res;

  // Picks one resource word out of the flat resource vector.
  function automatic bmc_word_t pick_res(input logic [`BMC_NRES*`BMC_DW-1:0] v, input bmc_sel_t s);
    bmc_word_t r;
    r = v[s*`BMC_DW +: `BMC_DW];
    return r;
  endfunction

  bmc_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .busy((state_q != BMC_IDLE) || settle_q),
    .pready(pready),
    .pslverr(pslverr),
    .wr_en(wr_en),
    .rd_en()
  );

  assign wr_ctrl = wr_en && (paddr == `BMC_OFF_CTRL);
  assign wr_romh = wr_en && (paddr == `BMC_OFF_ROMH);
  assign wr_stat = wr_en && (paddr == `BMC_OFF_INT_STAT);
  assign wr_mask = wr_en && (paddr == `BMC_OFF_INT_MASK);
  assign wr_cmp_load = wr_en && (paddr == `BMC_OFF_CMP_LOAD);
  assign wr_data_load = wr_en && (paddr == `BMC_OFF_DATA_LOAD);

  // The swap engine sees the selected resource, compare value and data value.
  bmc_swap_unit #(
    .RES_RESET(RES_RESET)
  ) u_swap (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_q),
    .sel(resource_select_q),
    .cmp(cmp_q),
    .data(data_q),
    .done_q(swap_done),
    .match_q(swap_match),
    .old_q(old_value),
    .res_flat(res_values)
  );

  // Sequencer that holds the bus off while a swap is running.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BMC_IDLE:
      begin
        if (wr_ctrl)
          state_d = BMC_BUSY;
      end
      BMC_BUSY:
      begin
        if (swap_done)
          state_d = BMC_IDLE;
      end
      default: state_d = BMC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= BMC_IDLE;
    else
      state_q <= state_d;
  end

  // Holds the bus one more cycle after an internal update so that registered read data is fresh.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_q <= 1'b0;
    else
      settle_q <= swap_done || boot_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_q <= 1'b0;
    else
      start_q <= wr_ctrl;
  end

  // Write clears it; a finishing swap wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      swap_complete_flag_q <= `BMC_DONE_RST;
    else if (swap_done)
      swap_complete_flag_q <= 1'b1;
    else if (wr_ctrl)
      swap_complete_flag_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      resource_select_q <= `BMC_SEL_RST;
    else if (wr_ctrl && pstrb[0])
      resource_select_q <= pwdata[`BMC_SEL_MSB:`BMC_SEL_LSB];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_q <= `BMC_WORD_RST;
      data_q <= `BMC_WORD_RST;
    end
    else
    begin
      if (wr_cmp_load)
        cmp_q <= bmc_merge(cmp_q, pwdata, pstrb);
      if (wr_data_load)
        data_q <= bmc_merge(data_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      info_len_q <= `BMC_BYTE_RST;
      crc_len_q <= `BMC_BYTE_RST;
    end
    else if (wr_romh)
    begin
      if (pstrb[3])
        info_len_q <= pwdata[`BMC_INFO_MSB:`BMC_INFO_LSB];
      if (pstrb[2])
        crc_len_q <= pwdata[`BMC_CRCL_MSB:`BMC_CRCL_LSB];
    end
  end

  assign romh_merged = bmc_merge({16'h0000, rom_crc_q}, pwdata, pstrb);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_q <= 1'b1;
      rom_crc_q <= `BMC_CRC_RST;
    end
    else if (boot_q)
    begin
      boot_q <= 1'b0;
      if (eeprom_present)
        rom_crc_q <= eeprom_crc;
    end
    else if (wr_romh)
    begin
      rom_crc_q <= romh_merged[`BMC_CRC_MSB:`BMC_CRC_LSB];
    end
  end

  assign rom_header = {info_len_q, crc_len_q, rom_crc_q};
  assign rom_header_live = link_on_bit;

  // Interrupt events, sticky status with write-one-to-clear, and mask.
  assign int_event[`BMC_INT_DONE] = swap_done;
  assign int_event[`BMC_INT_MATCH] = swap_done && swap_match;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat_q <= `BMC_INT_RST;
    else if (wr_stat && pstrb[0])
      int_stat_q <= (int_stat_q & ~pwdata[`BMC_INTW-1:0]) | int_event;
    else
      int_stat_q <= int_stat_q | int_event;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_mask_q <= `BMC_INT_RST;
    else if (wr_mask && pstrb[0])
      int_mask_q <= pwdata[`BMC_INTW-1:0];
  end

  assign irq = |(int_stat_q & int_mask_q);

  // Read multiplexer.
  always_comb
  begin
    rd_value = `BMC_WORD_RST;
    case (paddr)
      `BMC_OFF_DATA: rd_value = data_q;
      `BMC_OFF_CMP: rd_value = cmp_q;
      `BMC_OFF_CTRL:
      begin
        rd_value[`BMC_DONE_BIT] = swap_complete_flag_q;
        rd_value[`BMC_SEL_MSB:`BMC_SEL_LSB] = resource_select_q;
      end
      `BMC_OFF_ROMH: rd_value = rom_header;
      `BMC_OFF_BUSID: rd_value = `BMC_BUSID_VALUE;
      `BMC_OFF_CMP_LOAD: rd_value = cmp_q;
      `BMC_OFF_DATA_LOAD: rd_value = data_q;
      `BMC_OFF_OLD: rd_value = old_value;
      `BMC_OFF_INT_STAT: rd_value[`BMC_INTW-1:0] = int_stat_q;
      `BMC_OFF_INT_MASK: rd_value[`BMC_INTW-1:0] = int_mask_q;
      default: rd_value = `BMC_WORD_RST;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= `BMC_WORD_RST;
    else if (psel)
      prdata_q <= rd_value;
  end

  assign prdata = prdata_q;
  assign sel_res = pick_res(res_values, resource_select_q);

  sequence s_ctrl_wr;
    wr_ctrl;
  endsequence

  sequence s_swap_run;
    (state_q == BMC_BUSY) ##[SWAP_MIN:SWAP_MAX] swap_complete_flag_q;
  endsequence

  sequence s_read_of(bmc_addr_t a);
    psel && penable && pready && !pwrite && (paddr == a) && $past(psel);
  endsequence

  AST_SWAP_SEQ: assert property (@(posedge pclk) disable iff (!presetn)
    s_ctrl_wr |-> ##1 s_swap_run)
    else $error("compare-swap did not complete in time");

  AST_DONE_SET: assert property (@(posedge pclk) disable iff (!presetn)
    swap_done |=> swap_complete_flag_q && (state_q == BMC_IDLE))
    else $error("completion flag not set after swap");

  AST_WR_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> !swap_complete_flag_q)
    else $error("control write did not clear completion flag");

  AST_SEL_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pstrb[0]) |=> resource_select_q == $past(pwdata[`BMC_SEL_MSB:`BMC_SEL_LSB]))
    else $error("resource select not stored");

  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_of(`BMC_OFF_CTRL) |-> prdata[`BMC_DONE_BIT-1:`BMC_SEL_MSB+1] == '0)
    else $error("control reserved bits not zero");

  AST_BUSID: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_of(`BMC_OFF_BUSID) |-> prdata == `BMC_BUSID_VALUE)
    else $error("bus identification value wrong");

  AST_CMP_READ: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_of(`BMC_OFF_CMP) ##0 $stable(cmp_q) |-> prdata == cmp_q)
    else $error("compare register readback wrong");

  AST_MATCH_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    (swap_done && swap_match) |-> sel_res == data_q)
    else $error("matching swap did not store data value");

  AST_OLD: assert property (@(posedge pclk) disable iff (!presetn)
    swap_done |-> old_value == $past(sel_res))
    else $error("prior resource value not captured");

  AST_EEPROM: assert property (@(posedge pclk) disable iff (!presetn)
    (boot_q && eeprom_present) |=> rom_crc_q == $past(eeprom_crc))
    else $error("ROM CRC not loaded from EEPROM");

  AST_ROMH_WR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_romh && !boot_q && (pstrb == 4'hf)) |=> rom_header == $past(pwdata))
    else $error("ROM header write lost");

  AST_LEN_RST: assert property (@(posedge pclk) disable iff (!presetn)
    boot_q |-> (info_len_q == `BMC_BYTE_RST) && (crc_len_q == `BMC_BYTE_RST))
    else $error("length bytes not zero after reset");
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the compare-swap, ROM header and bus identification register bank.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defines.svh"
module tb_top;
  import bmc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  bmc_addr_t paddr = '0;
  bmc_word_t pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  bmc_word_t prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic eeprom_present = 1'b0;
  logic [15:0] eeprom_crc = 16'h0000;
  logic link_on_bit = 1'b0;
  bmc_word_t rom_header;
  logic rom_header_live;
  logic [`BMC_NRES*`BMC_DW-1:0] res_values;
  int bad_count = 0;
  int checks = 0;
  bmc_word_t rv;
  logic er;

  always #50 pclk = ~pclk;

  bmc_regs u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .eeprom_present(eeprom_present), .eeprom_crc(eeprom_crc),
    .link_on_bit(link_on_bit), .rom_header(rom_header), .rom_header_live(rom_header_live),
    .res_values(res_values)
  );

  task automatic end_of_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input bmc_word_t got, input bmc_word_t exp);
    checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  // One APB transfer; pready, prdata and pslverr are taken at the rising edge that ends the access.
  task automatic apb(input logic wr, input bmc_addr_t a, input bmc_word_t d, output bmc_word_t rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        bad_count++;
        end_of_test();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input bmc_addr_t a, input bmc_word_t d);
    apb(1'b1, a, d, rv, er);
  endtask

  task automatic rdc(input bmc_addr_t a, input bmc_word_t exp);
    apb(1'b0, a, '0, rv, er);
    chk(rv, exp);
  endtask

  task automatic do_reset(input logic ep, input logic [15:0] crc);
    @(posedge pclk);
    presetn <= 1'b0;
    eeprom_present <= ep;
    eeprom_crc <= crc;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic t_reset();
    do_reset(1'b1, 16'h5a5a);
    rdc(8'h14, 32'h80000000);
    rdc(8'h1c, 32'h31333934);
    rdc(8'h18, 32'h00005a5a);
    do_reset(1'b0, 16'hffff);
    rdc(8'h18, 32'h00000000);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_rom();
    wr(8'h18, 32'h04a1b2c3);
    link_on_bit <= 1'b1;
    rdc(8'h18, 32'h04a1b2c3);
    chk(rom_header, 32'h04a1b2c3);
    chk({31'h0, rom_header_live}, 32'h1);
    wr(8'h1c, 32'h00000000);
    rdc(8'h1c, 32'h31333934);
  endtask

  task automatic t_swap_all();
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h30, 32'h0);
      wr(8'h34, 32'h100 + i);
      wr(8'h10, 32'hffffffff);
      rdc(8'h10, 32'h0);
      // Start a swap on each resource.
      wr(8'h14, i);
      rdc(8'h14, 32'h80000000 | i);
      chk(res_values[i*32 +: 32], 32'h100 + i);
      rdc(8'h38, 32'h0);
      rdc(8'h0c, 32'h100 + i);
    end
  endtask

  task automatic t_swap_miss();
    wr(8'h30, 32'h00000bad);
    wr(8'h34, 32'h0000dead);
    rdc(8'h10, 32'h00000bad);
    wr(8'h14, 32'hfffffffd);
    rdc(8'h14, 32'h80000001);
    chk(res_values[63:32], 32'h101);
    rdc(8'h38, 32'h101);
  endtask

  task automatic t_irq();
    wr(8'h40, 32'h3);
    rdc(8'h40, 32'h0);
    wr(8'h44, 32'h0);
    wr(8'h30, 32'h102);
    wr(8'h34, 32'h55);
    wr(8'h14, 32'h2);
    rdc(8'h40, 32'h3);
    chk(res_values[95:64], 32'h55);
    chk({31'h0, irq}, 32'h0);
    wr(8'h44, 32'h2);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h40, 32'h2);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    rdc(8'h40, 32'h1);
  endtask

  task automatic t_unmapped();
    apb(1'b1, 8'h24, 32'h12345678, rv, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h24, '0, rv, er);
    chk({31'h0, er}, 32'h1);
    chk(rv, 32'h0);
    rdc(8'h14, 32'h80000002);
  endtask

  initial
  begin
    t_reset();
    t_rom();
    t_swap_all();
    t_swap_miss();
    t_irq();
    t_unmapped();
    end_of_test();
  end
endmodule
`default_nettype wire
